/* tb.sv */
// self-checking bench of the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpo_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [31:0] addr = '0;
  logic [15:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] hi_n = 3'h7;
  logic [2:0] lo_n = 3'h7;
  logic sync = 1'b0;
  logic trip_n = 1'b1;
  logic clr = 1'b0;
  logic half = 1'b0;
  logic [15:0] rdata, got, on_cnt;
  logic [5:0] pwm_n, gate_on;
  logic psync, run, tirq, sfiq;
  tpo_ctrl_s ctrl;
  tpo_timing_s tcfg;
  int errors = 0;
  int checked = 0;
  int i;
  logic [8:0] xv [8] = '{9'h000, 9'h100, 9'h080, 9'h040, 9'h120, 9'h0A7,
                         9'h1FF, 9'h000};
  always #20 clk_i = ~clk_i;

  tpo_output_stage i_tpo_output_stage (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .tu_hi_n_i(hi_n), .tu_lo_n_i(lo_n),
    .tu_sync_i(sync), .tu_half_i(half), .fault_trip_n_i(trip_n),
    .pwm_n_o(pwm_n), .period_sync_pulse_o(psync), .timer_run_o(run),
    .trip_irq_o(tirq), .sync_fiq_o(sfiq), .pwm_control_o(ctrl),
    .timing_cfg_o(tcfg));
  tpo_gate_drv i_tpo_gate_drv (.clk_i(clk_i), .clr_i(clr),
    .pwm_n_i(pwm_n), .gate_on_o(gate_on), .on_cnt_o(on_cnt));

  // ---------------------------------------------------------------
  // bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rdd(input logic [31:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // one raw sync pulse; the delayed pulse is looked at in its only cycle
  task automatic pulse(input logic e);
    @(posedge clk_i);
    sync <= 1'b1;
    @(posedge clk_i);
    sync <= 1'b0;
    #1 chk({15'h0, psync}, {15'h0, e});
    repeat (3) @(posedge clk_i);
  endtask
  // restart needs period and all three duties written
  task automatic load4;
    wrr(ADDR_PERIOD, 16'h0100);
    wrr(ADDR_DUTY_A, 16'h0040);
    wrr(ADDR_DUTY_B, 16'h0040);
    wrr(ADDR_DUTY_C, 16'h0040);
    repeat (3) @(posedge clk_i);
  endtask
  // routing first, then disable: a disabled pin stays high
  function automatic logic [5:0] xp(input logic [8:0] r);
    logic [5:0] e;
    int p;
    for (p = 0; p < 3; p++) begin
      e[4-2*p] = (r[8-p] ? lo_n[p] : hi_n[p]) | r[4-2*p];
      e[5-2*p] = (r[8-p] ? hi_n[p] : lo_n[p]) | r[5-2*p];
    end
    return e;
  endfunction
  task automatic close_out;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk({10'h0, pwm_n}, 16'h003F);
    rdd(ADDR_XOVR_DIS);
    chk(got, 16'h0000);
    rdd(ADDR_CHOP);
    chk(got, 16'h0000);
    rdd(ADDR_STATUS);
    chk(got, 16'h0008);
    wrr(ADDR_XOVR_DIS, 16'hFFFF);
    rdd(ADDR_XOVR_DIS);
    chk(got, 16'h01FF);
    wrr(ADDR_CHOP, 16'hFFFF);
    rdd(ADDR_CHOP);
    chk(got, 16'h03FF);
    wrr(ADDR_CTRL, 16'hFFFE);
    rdd(ADDR_CTRL);
    chk(got, 16'h001E);
    chk({11'h0, ctrl}, 16'h001E);
    rdd(32'hFFFFFC40);
    chk(got, 16'h0000);
    wrr(ADDR_CHOP, 16'h0000);
    wrr(ADDR_XOVR_DIS, 16'h0000);
    hi_n <= 3'h2;
    lo_n <= 3'h5;
    // run in double update mode so mid-period sync edges are covered too
    wrr(ADDR_CTRL, 16'h0005);
    pulse(1'b1);
    #1 chk({10'h0, pwm_n}, 16'h003F);
    load4();
    #1 chk({15'h0, run}, 16'h0001);
    chk(tcfg.switching_period, 16'h0100);
    rdd(ADDR_DUTY_C);
    chk(got, 16'h0040);
    for (i = 1; i < 8; i++) begin
      wrr(ADDR_XOVR_DIS, {7'h0, xv[i]});
      repeat (3) @(posedge clk_i);
      #1 chk({10'h0, pwm_n}, {10'h0, xp(xv[i-1])});
      pulse(1'b1);
      #1;
      chk(16'(pwm_n), 16'(xp(xv[i])));
    end
    // chop is only reprogrammed with the stage stopped
    wrr(ADDR_CTRL, 16'h0004);
    wrr(ADDR_CHOP, 16'h0101);
    wrr(ADDR_CTRL, 16'h0005);
    // divider 1 gives an 8-cycle carrier, on for 4 of them
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (16) @(posedge clk_i);
    #1 chk(on_cnt, 16'h0008);
    @(posedge clk_i);
    trip_n <= 1'b0;
    #1 chk({10'h0, pwm_n}, 16'h003F);
    repeat (4) @(posedge clk_i);
    #1 chk({14'h0, tirq, run}, 16'h0002);
    pulse(1'b0);
    half <= 1'b1;
    rdd(ADDR_STATUS);
    chk(got & 16'h0309, 16'h0301);
    wrr(ADDR_STATUS, 16'h0300);
    #1 chk({14'h0, tirq, sfiq}, 16'h0000);
    rdd(ADDR_CTRL);
    chk(got, 16'h0004);
    // chop switched off while stopped, before the restart
    wrr(ADDR_CHOP, 16'h0000);
    @(posedge clk_i);
    trip_n <= 1'b1;
    wrr(ADDR_CTRL, 16'h0005);
    repeat (4) @(posedge clk_i);
    #1 chk({15'h0, run}, 16'h0000);
    load4();
    #1 chk({15'h0, run}, 16'h0001);
    close_out();
  end

  // a hang ends the run as a failure
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

/* tpo_chop_carrier.sv */
// gate chop carrier: square wave of 4 x (divider + 1) core cycles
`timescale 1ns/1ps
`default_nettype none
module tpo_chop_carrier
  import tpo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [CHOP_DIV_W-1:0] chop_divider_i,
  output logic active_o
);

  logic [CHOP_DIV_W-1:0] pre_cnt;
  logic [1:0] quarter;
  logic pre_wrap;

  // one quarter of the carrier lasts divider + 1 cycles
  assign pre_wrap = (pre_cnt >= chop_divider_i);

  // ---------------------------------------------------------------
  // prescaler and quarter counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pre_cnt <= '0;
      quarter <= 2'h0;
    end else if (pre_wrap) begin
      pre_cnt <= '0;
      quarter <= quarter + 2'h1;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // first two quarters are the active half
  assign active_o = ~quarter[1];

endmodule
`default_nettype wire

/* tpo_gate_drv.sv */
// gate driver model seen by the output stage
`timescale 1ns/1ps
`default_nettype none
module tpo_gate_drv
  import tpo_pkg::*;
#(
  parameter int SEL = 4
) (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [NUM_OUTS-1:0] pwm_n_i,
  output logic [NUM_OUTS-1:0] gate_on_o,
  output logic [15:0] on_cnt_o
);
  // low command turns a switch on, high leaves it off
  assign gate_on_o = ~pwm_n_i;
  // on-cycle count of one switch, so chop duty can be measured
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      on_cnt_o <= 16'h0000;
    end else if (gate_on_o[SEL]) begin
      on_cnt_o <= on_cnt_o + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* tpo_output_stage.sv */
// three-phase pwm output stage: crossover, disable, chopping and trip
//
// Notes on behaviour
// - crossover/disable register is nine bits, read/write
// - bits 8,7,6 cross phases 0,1,2
// - crossover swaps high and low timing signals
// - crossover bits clear after reset
// - bits 0..5 force one output off
// - disable gating follows the crossover routing
// - disable bits clear after reset
// - crossover/disable latched on sync rising edge
// - chop register ten bits, high/low enables
// - chop period is 4 x (divider+1) cycles
// - chop register clears after reset
// - trip low forces outputs high asynchronously
// - no sync pulse while trip active
// - status bit 3 shows trip level
// - trip raises interrupt and halts timing
// - restart needs period and three duties rewritten
// - resume when rewritten and trip high
// - trip on normal line, sync on fast
// - control bit 0 enables, trip clears it
// - control bit 2 selects double update
// - bits 1,4,3 sync enable, source, mode
// - outputs active low, high is off
// - no output until period and duties written
`timescale 1ns/1ps
`default_nettype none
module tpo_output_stage
  import tpo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [DATA_W-1:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [DATA_W-1:0] bus_rdata_o,
  input wire logic [NUM_PHASES-1:0] tu_hi_n_i,
  input wire logic [NUM_PHASES-1:0] tu_lo_n_i,
  input wire logic tu_sync_i,
  input wire logic tu_half_i,
  input wire logic fault_trip_n_i,
  output logic [NUM_OUTS-1:0] pwm_n_o,
  output logic period_sync_pulse_o,
  output logic timer_run_o,
  output logic trip_irq_o,
  output logic sync_fiq_o,
  output tpo_ctrl_s pwm_control_o,
  output tpo_timing_s timing_cfg_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr,
                               input logic [31:0] base);
    hit = (addr == base);
  endfunction

  logic wr_ctrl, wr_status, wr_period, wr_dead, wr_chop;
  logic wr_duty_a, wr_duty_b, wr_duty_c, wr_xovr, wr_sync_w;

  assign wr_ctrl = bus_wr_i && hit(bus_addr_i, ADDR_CTRL);
  assign wr_status = bus_wr_i && hit(bus_addr_i, ADDR_STATUS);
  assign wr_period = bus_wr_i && hit(bus_addr_i, ADDR_PERIOD);
  assign wr_dead = bus_wr_i && hit(bus_addr_i, ADDR_DEAD);
  assign wr_chop = bus_wr_i && hit(bus_addr_i, ADDR_CHOP);
  assign wr_duty_a = bus_wr_i && hit(bus_addr_i, ADDR_DUTY_A);
  assign wr_duty_b = bus_wr_i && hit(bus_addr_i, ADDR_DUTY_B);
  assign wr_duty_c = bus_wr_i && hit(bus_addr_i, ADDR_DUTY_C);
  assign wr_xovr = bus_wr_i && hit(bus_addr_i, ADDR_XOVR_DIS);
  assign wr_sync_w = bus_wr_i && hit(bus_addr_i, ADDR_SYNC_WIDTH);

  // ---------------------------------------------------------------
  // trip synchroniser and trip state
  // ---------------------------------------------------------------
  logic trip_s;      // synchronised pin level, high = no fault
  logic trip_s_q;
  logic trip_fall;
  logic tripped;     // held from a trip until the rewrite is complete
  logic trip_hold;
  logic [3:0] written;
  logic all_written;

  // status and interrupt see the pin only after two flops
  tpo_sync2 #(
    .RST_VAL(1'b1)
  ) u_trip_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(fault_trip_n_i),
    .sync_o(trip_s)
  );

  assign trip_fall = trip_s_q & ~trip_s;
  assign all_written = (written == WRITTEN_ALL);
  assign trip_hold = tripped | ~trip_s;

  // a trip wipes the record of writes, so a full rewrite is needed
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      trip_s_q <= 1'b1;
      written <= 4'h0;
    end else begin
      trip_s_q <= trip_s;
      if (trip_fall) begin
        written <= 4'h0;
      end else begin
        written <= written | {wr_duty_c, wr_duty_b, wr_duty_a, wr_period};
      end
    end
  end

  // leave the tripped state once rewritten and the pin is high again
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tripped <= 1'b0;
    end else if (trip_fall) begin
      tripped <= 1'b1;
    end else if (all_written && trip_s) begin
      tripped <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  tpo_ctrl_s next_ctrl;

  // the trip clear beats a software write in the same cycle
  always_comb begin
    next_ctrl = pwm_control_o;
    if (wr_ctrl) begin
      next_ctrl.pwm_enable = bus_wdata_i[CTRL_ENABLE_BIT];
      next_ctrl.sync_enable = bus_wdata_i[CTRL_SYNC_EN_BIT];
      next_ctrl.double_update_select = bus_wdata_i[CTRL_DOUBLE_BIT];
      next_ctrl.ext_sync_mode = bus_wdata_i[CTRL_EXT_MODE_BIT];
      next_ctrl.sync_source_select = bus_wdata_i[CTRL_SYNC_SRC_BIT];
    end
    if (trip_fall) begin
      next_ctrl.pwm_enable = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwm_control_o <= CTRL_RST;
    end else begin
      pwm_control_o <= next_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // timing unit registers, passed straight on
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      timing_cfg_o <= TIMING_RST;
    end else begin
      if (wr_period) begin
        timing_cfg_o.switching_period <= bus_wdata_i;
      end
      if (wr_dead) begin
        timing_cfg_o.dead_time <= bus_wdata_i[DEAD_W-1:0];
      end
      if (wr_duty_a) begin
        timing_cfg_o.phase_a_duty <= bus_wdata_i;
      end
      if (wr_duty_b) begin
        timing_cfg_o.phase_b_duty <= bus_wdata_i;
      end
      if (wr_duty_c) begin
        timing_cfg_o.phase_c_duty <= bus_wdata_i;
      end
      if (wr_sync_w) begin
        timing_cfg_o.sync_width <= bus_wdata_i[DEAD_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // crossover/disable and chop configuration
  // ---------------------------------------------------------------
  logic [XOVR_DIS_W-1:0] xovr_dis;      // software copy
  logic [XOVR_DIS_W-1:0] xovr_dis_act;  // copy in force
  logic [CHOP_W-1:0] chop_cfg;
  logic sync_q;
  logic sync_rise;
  logic sync_ok;

  assign sync_rise = tu_sync_i & ~sync_q;
  assign sync_ok = sync_rise & ~trip_hold;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      xovr_dis <= XOVR_DIS_RST;
      chop_cfg <= CHOP_RST;
    end else begin
      if (wr_xovr) begin
        xovr_dis <= bus_wdata_i[XOVR_DIS_W-1:0];
      end
      if (wr_chop) begin
        chop_cfg <= bus_wdata_i[CHOP_W-1:0];
      end
    end
  end

  // a new pattern only takes over on a sync edge, so no half-changed
  // commutation step ever reaches the gates
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_q <= 1'b0;
      xovr_dis_act <= XOVR_DIS_RST;
    end else begin
      sync_q <= tu_sync_i;
      if (sync_ok) begin
        xovr_dis_act <= xovr_dis;
      end
    end
  end

  // ---------------------------------------------------------------
  // chop carrier
  // ---------------------------------------------------------------
  logic chop_active;

  // divider is read live, so changing it while running glitches
  tpo_chop_carrier u_chop (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .chop_divider_i(chop_cfg[CHOP_DIV_LSB +: CHOP_DIV_W]),
    .active_o(chop_active)
  );

  // ---------------------------------------------------------------
  // output path per phase
  // ---------------------------------------------------------------
  logic [NUM_OUTS-1:0] routed_n;
  logic [NUM_OUTS-1:0] gated_n;
  logic [NUM_OUTS-1:0] chop_off;
  logic [NUM_OUTS-1:0] next_pwm_n;
  logic run_next;

  genvar p;
  generate
    for (p = 0; p < NUM_PHASES; p++) begin : g_phase
      logic xo;
      assign xo = xovr_dis_act[XOVR_BIT_PHASE0 - p];
      // swap the pair when crossed over
      assign routed_n[DIS_HI_PHASE0 - 2*p] = xo ? tu_lo_n_i[p] : tu_hi_n_i[p];
      assign routed_n[DIS_LO_PHASE0 - 2*p] = xo ? tu_hi_n_i[p] : tu_lo_n_i[p];
    end
  endgenerate

  // disable acts after the swap, off is high
  assign gated_n = routed_n | xovr_dis_act[NUM_OUTS-1:0];

  // chopped sides go off in the idle half of the carrier
  assign chop_off = ({NUM_OUTS{chop_cfg[CHOP_HI_BIT]}} & HI_SIDE_MASK |
                     {NUM_OUTS{chop_cfg[CHOP_LO_BIT]}} & LO_SIDE_MASK) &
                    {NUM_OUTS{~chop_active}};

  // nothing drives the gates until set up and free of trips
  assign run_next = pwm_control_o.pwm_enable & all_written & ~trip_hold;
  assign next_pwm_n = timer_run_o ? (gated_n | chop_off) : OUT_OFF;

  // the trip pin sets the outputs without a clock edge
  always_ff @(posedge clk_i or negedge fault_trip_n_i) begin
    if (!fault_trip_n_i) begin
      pwm_n_o <= OUT_OFF;
    end else if (!rstn_i) begin
      pwm_n_o <= OUT_OFF;
    end else begin
      pwm_n_o <= next_pwm_n;
    end
  end

  // ---------------------------------------------------------------
  // run, sync and interrupt flags
  // ---------------------------------------------------------------
  // software clears a flag with a one; a new event wins the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_run_o <= 1'b0;
      period_sync_pulse_o <= 1'b0;
      trip_irq_o <= 1'b0;
      sync_fiq_o <= 1'b0;
    end else begin
      timer_run_o <= run_next;
      period_sync_pulse_o <= tu_sync_i & ~trip_hold;
      // trip goes to the normal line only
      if (trip_fall) begin
        trip_irq_o <= 1'b1;
      end else if (wr_status && bus_wdata_i[STAT_TRIP_INT_BIT]) begin
        trip_irq_o <= 1'b0;
      end
      // sync goes to the fast line only
      if (sync_ok) begin
        sync_fiq_o <= 1'b1;
      end else if (wr_status && bus_wdata_i[STAT_SYNC_INT_BIT]) begin
        sync_fiq_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] status_val;
  logic [DATA_W-1:0] rd_mux;

  assign status_val = {6'h00, sync_fiq_o, trip_irq_o, 4'h0,
                       trip_s, 2'h0, tu_half_i};

  assign rd_mux =
    hit(bus_addr_i, ADDR_CTRL) ? {11'h000, pwm_control_o} :
    hit(bus_addr_i, ADDR_STATUS) ? status_val :
    hit(bus_addr_i, ADDR_PERIOD) ? timing_cfg_o.switching_period :
    hit(bus_addr_i, ADDR_DEAD) ? {6'h00, timing_cfg_o.dead_time} :
    hit(bus_addr_i, ADDR_CHOP) ? {6'h00, chop_cfg} :
    hit(bus_addr_i, ADDR_DUTY_A) ? timing_cfg_o.phase_a_duty :
    hit(bus_addr_i, ADDR_DUTY_B) ? timing_cfg_o.phase_b_duty :
    hit(bus_addr_i, ADDR_DUTY_C) ? timing_cfg_o.phase_c_duty :
    hit(bus_addr_i, ADDR_XOVR_DIS) ? {7'h00, xovr_dis} :
    hit(bus_addr_i, ADDR_SYNC_WIDTH) ? {6'h00, timing_cfg_o.sync_width} :
    16'h0000;

  // unmapped addresses read as zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bus_rdata_o <= 16'h0000;
    end else if (bus_rd_i) begin
      bus_rdata_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_disable_forces_off: assert property (
    xovr_dis_act[0] |=> pwm_n_o[0])
    else $error("disabled output was driven low");

  chk_reset_clears_xovr: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rstn_i |=> (xovr_dis == 9'h000) && (xovr_dis_act == 9'h000))
    else $error("crossover/disable not clear after reset");

  chk_reset_clears_chop: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rstn_i |=> chop_cfg == 10'h000)
    else $error("chop config not clear after reset");

  chk_trip_outputs_off: assert property (
    !fault_trip_n_i |-> pwm_n_o == 6'h3F)
    else $error("outputs not off during trip");

  chk_sync_suppressed: assert property (
    tripped |=> !period_sync_pulse_o)
    else $error("sync pulse during trip shutdown");

  chk_status_trip_lag: assert property (
    ##2 trip_s == $past(fault_trip_n_i, 2))
    else $error("status trip bit not two cycles behind pin");

  chk_trip_irq_halt: assert property (
    trip_fall |=> trip_irq_o && !pwm_control_o.pwm_enable && !timer_run_o)
    else $error("trip did not raise interrupt and halt");

  chk_latch_only_sync: assert property (
    !sync_ok |=> $stable(xovr_dis_act))
    else $error("crossover/disable changed off a sync edge");

  chk_run_needs_writes: assert property (
    !all_written |=> !timer_run_o ##1 pwm_n_o == 6'h3F)
    else $error("ran before period and duties written");

  chk_chop_high_side: assert property (
    chop_cfg[CHOP_HI_BIT] && !chop_active |=> pwm_n_o[4] && pwm_n_o[2])
    else $error("chopped high side active in idle half");

  chk_crossover_route: assert property (
    timer_run_o && fault_trip_n_i && xovr_dis_act[8] && !xovr_dis_act[5]
      && !chop_cfg[CHOP_LO_BIT] |=> pwm_n_o[5] == $past(tu_hi_n_i[0]))
    else $error("crossover did not route high side to low pin");

  cov_crossover: cover property (timer_run_o && xovr_dis_act[7]);
  cov_trip_restart: cover property (tripped ##[1:200] !tripped);
  cov_chop_both: cover property (chop_cfg[9:8] == 2'h3 && timer_run_o);
  cov_double: cover property (pwm_control_o.double_update_select && sync_ok);

endmodule
`default_nettype wire

/* tpo_pkg.sv */
// package: constants, register map and carrier types of the pwm output stage
package tpo_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_CTRL = 32'hFFFFFC00;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFFFC04;
  localparam logic [31:0] ADDR_PERIOD = 32'hFFFFFC08;
  localparam logic [31:0] ADDR_DEAD = 32'hFFFFFC0C;
  localparam logic [31:0] ADDR_CHOP = 32'hFFFFFC10;
  localparam logic [31:0] ADDR_DUTY_A = 32'hFFFFFC14;
  localparam logic [31:0] ADDR_DUTY_B = 32'hFFFFFC18;
  localparam logic [31:0] ADDR_DUTY_C = 32'hFFFFFC1C;
  localparam logic [31:0] ADDR_XOVR_DIS = 32'hFFFFFC20;
  localparam logic [31:0] ADDR_SYNC_WIDTH = 32'hFFFFFC24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SYNC_EN_BIT = 1;
  localparam int CTRL_DOUBLE_BIT = 2;
  localparam int CTRL_EXT_MODE_BIT = 3;
  localparam int CTRL_SYNC_SRC_BIT = 4;
  localparam int STAT_HALF_BIT = 0;
  localparam int STAT_TRIP_BIT = 3;
  localparam int STAT_TRIP_INT_BIT = 8;
  localparam int STAT_SYNC_INT_BIT = 9;
  localparam int CHOP_DIV_LSB = 0;
  localparam int CHOP_DIV_W = 8;
  localparam int CHOP_HI_BIT = 8;
  localparam int CHOP_LO_BIT = 9;
  localparam int XOVR_BIT_PHASE0 = 8;  // phase p uses bit 8 - p
  localparam int DIS_HI_PHASE0 = 4;    // phase p high side: bit 4 - 2p
  localparam int DIS_LO_PHASE0 = 5;    // phase p low side: bit 5 - 2p
  localparam int XOVR_DIS_W = 9;
  localparam int CHOP_W = 10;
  localparam int DEAD_W = 10;
  localparam int DUTY_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_PHASES = 3;
  localparam int NUM_OUTS = 6;
  localparam int CHOP_QUARTERS = 4;    // carrier period is 4 x (div + 1)

  // ---------------------------------------------------------------
  // reset values and fixed levels
  // ---------------------------------------------------------------
  localparam logic [XOVR_DIS_W-1:0] XOVR_DIS_RST = 9'h000;
  localparam logic [CHOP_W-1:0] CHOP_RST = 10'h000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
  localparam logic [DEAD_W-1:0] DEAD_RST = 10'h000;
  localparam logic [NUM_OUTS-1:0] OUT_OFF = 6'h3F;  // active low, off = high
  localparam logic [NUM_OUTS-1:0] HI_SIDE_MASK = 6'h15;
  localparam logic [NUM_OUTS-1:0] LO_SIDE_MASK = 6'h2A;
  localparam logic [3:0] WRITTEN_ALL = 4'hF;  // period, duty a, b, c

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sync_source_select;
    logic ext_sync_mode;
    logic double_update_select;
    logic sync_enable;
    logic pwm_enable;
  } tpo_ctrl_s;

  localparam tpo_ctrl_s CTRL_RST = 5'h00;

  typedef struct packed {
    logic [DUTY_W-1:0] switching_period;
    logic [DEAD_W-1:0] dead_time;
    logic [DUTY_W-1:0] phase_a_duty;
    logic [DUTY_W-1:0] phase_b_duty;
    logic [DUTY_W-1:0] phase_c_duty;
    logic [DEAD_W-1:0] sync_width;
  } tpo_timing_s;

  localparam tpo_timing_s TIMING_RST = '0;

endpackage

/* tpo_sync2.sv */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module tpo_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta;

  // ---------------------------------------------------------------
  // stage one is read only by stage two
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire
